// ===== src/scd_bank.sv
// register bank and channel selection for the synthesizer divider chain
`timescale 1ns/100ps
`default_nettype none
`include "scd_cfg.svh"

// What this block does
// - The feedback chain always divides the oscillator by two first.
// - The band divider divides by 1 for high bands, 2 at 434, 3 at 315 MHz.
// - The band divider ratio comes from bits 3:2 of the config at 0x04.
// - A multi-modulus factor is produced by a modulator from the words.
// - Four channel sets are held and a transmit command picks the active one.
// - The fraction is applied as (frac+0.5)/(2^21-0.5) on top of the integer.
// - Band code 00,01,10,11 selects 315, 434, 868 and 915 MHz bands.
// - Each channel has a seven-bit integer in bits 6:0, bit 7 unused.
// - Each channel fraction byte 0 holds fraction bits 7:0.
// - Byte 1 holds bits 15:8 at 0x0b..0x17, byte 2 holds bits 20:16.
module scd_bank
  import scd_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // wishbone slave
  input  wire logic        wb_cyc,
  input  wire logic        wb_stb,
  input  wire logic        wb_we,
  input  wire logic [3:0]  wb_sel,
  input  wire logic [7:0]  wb_adr,
  input  wire logic [31:0] wb_wdata,
  output logic [31:0]      wb_rdata,
  output logic             wb_ack,
  // divider chain configuration
  output logic [1:0]       prescale_ratio,
  output logic [1:0]       band_ratio,
  output logic [1:0]       band_select,
  output logic [1:0]       active_chan,
  output logic [6:0]       integer_ratio,
  output logic [20:0]      fraction_ratio,
  output logic [7:0]       mmd_factor
);

  scd_state_t s_r;
  scd_state_t s_nxt;
  logic [5:0] idx;
  scd_kind_t  kind;
  logic [1:0] ch;
  logic       req;
  logic       wr;
  logic [7:0] rd;

  // =====================================================================
  // decode helpers
  function automatic scd_kind_t kind_of(input logic [5:0] i);
    logic [5:0] off;
    off = i - `SCD_IDX_CH_BASE;
    if (i == `SCD_IDX_TXCFG)
      return SCD_K_TXCFG;
    if (i == `SCD_IDX_CMD)
      return SCD_K_CMD;
    if (i == `SCD_IDX_STAT)
      return SCD_K_STAT;
    if (i < `SCD_IDX_CH_BASE || i > `SCD_IDX_CH_LAST)
      return SCD_K_NONE;
    unique case (off[1:0])
      2'h0:    return SCD_K_INT;
      2'h1:    return SCD_K_FR0;
      2'h2:    return SCD_K_FR1;
      default: return SCD_K_FR2;
    endcase
  endfunction

  function automatic logic [1:0] chan_of(input logic [5:0] i);
    logic [5:0] off;
    off = i - `SCD_IDX_CH_BASE;
    return off[3:2];
  endfunction

  function automatic logic [1:0] ratio_of(input logic [1:0] band);
    unique case (band)
      2'b00:   return `SCD_RATIO_315;
      2'b01:   return `SCD_RATIO_434;
      default: return `SCD_RATIO_HIGH;
    endcase
  endfunction

  // =====================================================================
  // next state
  always_comb
  begin
    s_nxt = s_r;
    idx = wb_adr[7:2];
    kind = kind_of(idx);
    ch = chan_of(idx);
    req = wb_cyc & wb_stb & ~s_r.ack;
    wr = req & wb_we & wb_sel[0];
    rd = 8'h00;
    unique case (kind)
      SCD_K_TXCFG:
      begin
        rd = s_r.txcfg;
        if (wr)
          s_nxt.txcfg = wb_wdata[7:0];
      end
      SCD_K_INT:
      begin
        rd = `SCD_INT_NU | {1'b0, s_r.int_w[ch]};
        if (wr)
          s_nxt.int_w[ch] = wb_wdata[6:0];
      end
      SCD_K_FR0:
      begin
        rd = s_r.frac_w[ch][7:0];
        if (wr)
          s_nxt.frac_w[ch][7:0] = wb_wdata[7:0];
      end
      SCD_K_FR1:
      begin
        rd = s_r.frac_w[ch][15:8];
        if (wr)
          s_nxt.frac_w[ch][15:8] = wb_wdata[7:0];
      end
      SCD_K_FR2:
      begin
        rd = `SCD_FR2_NU | {3'h0, s_r.frac_w[ch][20:16]};
        if (wr)
          s_nxt.frac_w[ch][20:16] = wb_wdata[4:0];
      end
      SCD_K_CMD:
      begin
        rd = {6'h00, s_r.act_chan};
        if (wr)
        begin
          s_nxt.act_chan = wb_wdata[1:0];
          s_nxt.act_int = s_r.int_w[wb_wdata[1:0]];
          s_nxt.act_frac = s_r.frac_w[wb_wdata[1:0]];
          s_nxt.cmd_seen = 1'b1;
        end
      end
      SCD_K_STAT:
        rd = {s_r.cmd_seen, 3'h0, s_r.div.band_ratio, s_r.act_chan};
      SCD_K_NONE:
        rd = 8'h00;
    endcase
    s_nxt.ack = req;
    s_nxt.dat = req ? {24'h000000, rd} : 32'h00000000;
    s_nxt.div.prescale = `SCD_PRESCALE;
    s_nxt.div.band_ratio = ratio_of(s_r.txcfg[`SCD_BAND_HI:`SCD_BAND_LO]);
    s_nxt.div.chan = s_r.act_chan;
    if (s_r.txcfg[`SCD_BAND_HI])
      s_nxt.div.int_word = s_r.act_int;
    else
      s_nxt.div.int_word = {1'b0, s_r.act_int[5:0]};
    s_nxt.div.frac_word = s_r.act_frac;
  end

  // =====================================================================
  // state register
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      s_r <= '0;
      s_r.txcfg <= `SCD_TXCFG_RST;
      s_r.int_w <= {4{`SCD_INT_RST}};
      s_r.frac_w <= {4{`SCD_FRAC_RST}};
      s_r.act_int <= `SCD_INT_RST;
      s_r.act_frac <= `SCD_FRAC_RST;
      s_r.div.prescale <= `SCD_PRESCALE;
      s_r.div.band_ratio <= `SCD_RATIO_434;
      s_r.div.int_word <= {1'b0, 6'h00};
      s_r.div.frac_word <= `SCD_FRAC_RST;
    end
    else
      s_r <= s_nxt;
  end

  // =====================================================================
  // modulator
  scd_sigma_delta u_sd
  (
    .clock     (clock),
    .rstn      (rstn),
    .int_word  (s_r.div.int_word),
    .frac_word (s_r.div.frac_word),
    .factor    (mmd_factor)
  );

  // =====================================================================
  // outputs
  assign wb_rdata = s_r.dat;
  assign wb_ack = s_r.ack;
  assign prescale_ratio = s_r.div.prescale;
  assign band_ratio = s_r.div.band_ratio;
  assign band_select = s_r.txcfg[`SCD_BAND_HI:`SCD_BAND_LO];
  assign active_chan = s_r.div.chan;
  assign integer_ratio = s_r.div.int_word;
  assign fraction_ratio = s_r.div.frac_word;

  // =====================================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  sequence s_req;
    wb_cyc && wb_stb && !wb_ack;
  endsequence

  sequence s_cmd_wr;
    wr && kind == SCD_K_CMD;
  endsequence

  property p_ack_pulse;
    s_req |=> wb_ack ##1 !wb_ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack not a single cycle answer");

  property p_prescale;
    prescale_ratio == 2'h2;
  endproperty
  a_prescale: assert property (p_prescale)
    else $error("prescaler ratio not two");

  property p_band_315;
    band_select == 2'b00 |=> band_ratio == 2'h3;
  endproperty
  a_band_315: assert property (p_band_315)
    else $error("315 band ratio not three");

  property p_band_decode;
    ##1 band_ratio == ($past(band_select) == 2'b01 ? 2'h2 :
                       $past(band_select) == 2'b00 ? 2'h3 : 2'h1);
  endproperty
  a_band_decode: assert property (p_band_decode)
    else $error("band code decoded wrongly");

  property p_cmd_select;
    s_cmd_wr |=> ##1 active_chan == $past(wb_wdata[1:0], 2);
  endproperty
  a_cmd_select: assert property (p_cmd_select)
    else $error("transmit command did not select channel");

  property p_cmd_words;
    s_cmd_wr |=> s_r.act_int == $past(s_r.int_w[wb_wdata[1:0]]) &&
      s_r.act_frac == $past(s_r.frac_w[wb_wdata[1:0]]);
  endproperty
  a_cmd_words: assert property (p_cmd_words)
    else $error("transmit command copied wrong channel words");

  property p_words_hold;
    !(wr && kind == SCD_K_CMD) |=>
      $stable(s_r.act_int) && $stable(s_r.act_frac);
  endproperty
  a_words_hold: assert property (p_words_hold)
    else $error("active words changed without a command");

  property p_low_band_mask;
    !s_r.txcfg[`SCD_BAND_HI] |=> !integer_ratio[`SCD_INT_MSB];
  endproperty
  a_low_band_mask: assert property (p_low_band_mask)
    else $error("integer bit six used in low band");

  property p_int_read;
    req && !wb_we && kind == SCD_K_INT |=>
      wb_rdata[7:0] == {1'b1, $past(s_r.int_w[ch])};
  endproperty
  a_int_read: assert property (p_int_read)
    else $error("integer read wrong or unused bit not one");

  property p_frac0_write;
    wr && kind == SCD_K_FR0 |=>
      s_r.frac_w[$past(ch)][7:0] == $past(wb_wdata[7:0]);
  endproperty
  a_frac0_write: assert property (p_frac0_write)
    else $error("fraction low byte not stored");

  property p_frac2_read;
    req && !wb_we && kind == SCD_K_FR2 |=> wb_rdata[7:5] == 3'b110;
  endproperty
  a_frac2_read: assert property (p_frac2_read)
    else $error("fraction high byte unused bits wrong");

  property p_frac1_write;
    wr && kind == SCD_K_FR1 |=>
      s_r.frac_w[$past(ch)][15:8] == $past(wb_wdata[7:0]);
  endproperty
  a_frac1_write: assert property (p_frac1_write)
    else $error("fraction middle byte not stored");

endmodule
`default_nettype wire

// ===== src/scd_cfg.svh
// constants for the synthesizer channel divider register bank
`ifndef SCD_CFG_SVH
`define SCD_CFG_SVH

// =====================================================================
// register indices (byte address is four times the index)
`define SCD_IDX_TXCFG   6'h04
`define SCD_IDX_CH_BASE 6'h09
`define SCD_IDX_CH_LAST 6'h18
`define SCD_IDX_CMD     6'h30
`define SCD_IDX_STAT    6'h31

// =====================================================================
// field positions
`define SCD_BAND_HI     3
`define SCD_BAND_LO     2
`define SCD_INT_MSB     6
`define SCD_FR1_LSB     8
`define SCD_FR2_LSB     16
`define SCD_STAT_SEEN   7

// =====================================================================
// reset values and fixed read patterns
`define SCD_TXCFG_RST   8'h06
`define SCD_INT_RST     7'h40
`define SCD_FRAC_RST    21'h100000
`define SCD_INT_NU      8'h80
`define SCD_FR2_NU      8'hc0

// =====================================================================
// divider ratios
`define SCD_PRESCALE    2'h2
`define SCD_RATIO_315   2'h3
`define SCD_RATIO_434   2'h2
`define SCD_RATIO_HIGH  2'h1

// =====================================================================
// modulator modulus: (2f+1)/(2^22-1) equals (f+0.5)/(2^21-0.5)
`define SCD_SD_MOD      23'h3fffff

`endif

// ===== src/scd_pkg.sv
// types for the synthesizer channel divider register bank
package scd_pkg;

  typedef enum logic [7:0]
  {
    SCD_K_TXCFG = 8'h01,
    SCD_K_INT   = 8'h02,
    SCD_K_FR0   = 8'h04,
    SCD_K_FR1   = 8'h08,
    SCD_K_FR2   = 8'h10,
    SCD_K_CMD   = 8'h20,
    SCD_K_STAT  = 8'h40,
    SCD_K_NONE  = 8'h80
  } scd_kind_t;

  typedef struct packed {
    logic [1:0]  band_ratio;
    logic [1:0]  prescale;
    logic [1:0]  chan;
    logic [6:0]  int_word;
    logic [20:0] frac_word;
  } scd_div_cfg_t;

  typedef struct packed {
    logic [7:0]        txcfg;
    logic [3:0][6:0]   int_w;
    logic [3:0][20:0]  frac_w;
    logic [1:0]        act_chan;
    logic [6:0]        act_int;
    logic [20:0]       act_frac;
    logic              cmd_seen;
    logic              ack;
    logic [31:0]       dat;
    scd_div_cfg_t      div;
  } scd_state_t;

  typedef struct packed {
    logic [21:0] acc;
    logic [7:0]  factor;
  } scd_sd_state_t;

endpackage

// ===== src/scd_sigma_delta.sv
// first-order sigma-delta source of the multi-modulus division factor
`timescale 1ns/100ps
`default_nettype none
`include "scd_cfg.svh"

module scd_sigma_delta
  import scd_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // configured words
  input  wire logic [6:0]  int_word,
  input  wire logic [20:0] frac_word,
  // instantaneous division factor
  output logic [7:0]       factor
);

  scd_sd_state_t s_r;
  scd_sd_state_t s_nxt;
  logic [22:0]   sum;

  // =====================================================================
  // accumulator
  always_comb
  begin
    s_nxt = s_r;
    sum = {1'b0, s_r.acc} + {1'b0, frac_word, 1'b1};
    if (sum >= `SCD_SD_MOD)
    begin
      s_nxt.acc = 22'(sum - `SCD_SD_MOD);
      s_nxt.factor = {1'b0, int_word} + 8'h01;
    end
    else
    begin
      s_nxt.acc = sum[21:0];
      s_nxt.factor = {1'b0, int_word};
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign factor = s_r.factor;

  // =====================================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  property p_factor_range;
    ##1 ((factor == {1'b0, $past(int_word)}) ||
         (factor == {1'b0, $past(int_word)} + 8'h01));
  endproperty
  a_factor_range: assert property (p_factor_range)
    else $error("division factor outside int and int plus one");

  property p_acc_bound;
    s_r.acc < 22'h3fffff;
  endproperty
  a_acc_bound: assert property (p_acc_bound)
    else $error("modulator accumulator above modulus");

endmodule
`default_nettype wire

// ===== testbench/scd_host_model.sv
// host-side wishbone master model for the divider register bank
`timescale 1ns/100ps
`default_nettype none

module scd_host_model
(
  // clock
  input  wire logic        clock,
  // wishbone master side
  output var  logic        wb_cyc,
  output var  logic        wb_stb,
  output var  logic        wb_we,
  output var  logic [3:0]  wb_sel,
  output var  logic [7:0]  wb_adr,
  output var  logic [31:0] wb_wdata,
  input  wire logic [31:0] wb_rdata,
  input  wire logic        wb_ack
);
  initial
  begin
    wb_cyc   = 1'b0;
    wb_stb   = 1'b0;
    wb_we    = 1'b0;
    wb_sel   = 4'h0;
    wb_adr   = 8'h00;
    wb_wdata = 32'h0;
  end

  // one classic cycle; ok stays low when no answer comes
  task automatic xfer(input logic we, input logic [3:0] sel,
                      input logic [7:0] adr, input logic [31:0] wd,
                      output logic [31:0] rd, output logic ok);
    ok = 1'b0;
    rd = 32'h0;
    @(posedge clock);
    wb_cyc   <= 1'b1;
    wb_stb   <= 1'b1;
    wb_we    <= we;
    wb_sel   <= sel;
    wb_adr   <= adr;
    wb_wdata <= wd;
    for (int i = 0; i < 16 && !ok; i++)
    begin
      @(posedge clock);
      if (wb_ack === 1'b1)
      begin
        ok = 1'b1;
        rd = wb_rdata;
      end
    end
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask
endmodule

`default_nettype wire

// ===== testbench/tb_scd_bank.sv
// self-checking bench for the synthesizer divider register bank
`timescale 1ns/100ps
`default_nettype none

module tb_scd_bank
  import scd_pkg::*;
;
  logic        clock;
  logic        rstn;
  logic        wb_cyc;
  logic        wb_stb;
  logic        wb_we;
  logic [3:0]  wb_sel;
  logic [7:0]  wb_adr;
  logic [31:0] wb_wdata;
  logic [31:0] wb_rdata;
  logic        wb_ack;
  logic [1:0]  prescale_ratio;
  logic [1:0]  band_ratio;
  logic [1:0]  band_select;
  logic [1:0]  active_chan;
  logic [6:0]  integer_ratio;
  logic [20:0] fraction_ratio;
  logic [7:0]  mmd_factor;
  logic [31:0] rd;
  logic        ok;
  int          fails;
  int          comparisons;
  int          hi;
  logic [20:0] fr [4] = '{21'h100000, 21'h0abcde, 21'h1f00ff, 21'h012345};
  logic [1:0]  br [4] = '{2'h3, 2'h2, 2'h1, 2'h1};

  scd_bank i_dut (.clock(clock), .rstn(rstn), .wb_cyc(wb_cyc),
    .wb_stb(wb_stb), .wb_we(wb_we), .wb_sel(wb_sel), .wb_adr(wb_adr),
    .wb_wdata(wb_wdata), .wb_rdata(wb_rdata), .wb_ack(wb_ack),
    .prescale_ratio(prescale_ratio), .band_ratio(band_ratio),
    .band_select(band_select), .active_chan(active_chan),
    .integer_ratio(integer_ratio), .fraction_ratio(fraction_ratio),
    .mmd_factor(mmd_factor));

  scd_host_model i_host (.clock(clock), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
    .wb_we(wb_we), .wb_sel(wb_sel), .wb_adr(wb_adr), .wb_wdata(wb_wdata),
    .wb_rdata(wb_rdata), .wb_ack(wb_ack));

  // ===================================================================
  // reporting and bus tasks
  task automatic conclude();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask

  task automatic bus(input logic we, input logic [3:0] sel,
                     input logic [7:0] a, input logic [31:0] d);
    i_host.xfer(we, sel, a, d, rd, ok);
    if (ok !== 1'b1)
    begin
      $display("[ERR] wb_ack expected 1 seen 0");
      fails++;
      conclude();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, 4'h1, a, {24'h0, d});
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, 4'h1, a, 32'h0);
    chk("wb_rdata", {24'h0, e}, rd);
  endtask

  task automatic settle();
    repeat (3) @(negedge clock);
  endtask

  // ===================================================================
  // clock and test sequence
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  initial
  begin
    fails = 0;
    comparisons = 0;
    rstn = 1'b0;
    repeat (8) @(posedge clock);
    @(negedge clock);
    chk("prescale_ratio", 32'h2, prescale_ratio);
    chk("band_ratio", 32'h2, band_ratio);
    chk("band_select", 32'h1, band_select);
    @(posedge clock);
    rstn <= 1'b1;
    rd_chk(8'h10, 8'h06);
    rd_chk(8'hc4, 8'h08);
    for (int n = 0; n < 4; n++)
    begin
      rd_chk(8'h24 + 8'(16 * n), 8'hc0);
      rd_chk(8'h28 + 8'(16 * n), 8'h00);
      rd_chk(8'h2c + 8'(16 * n), 8'h00);
      rd_chk(8'h30 + 8'(16 * n), 8'hd0);
    end
    for (int b = 0; b < 4; b++)
    begin
      wr(8'h10, {4'h0, 2'(b), 2'h2});
      settle();
      chk("band_select", 32'(b), band_select);
      chk("band_ratio", {30'h0, br[b]}, band_ratio);
      chk("prescale_ratio", 32'h2, prescale_ratio);
    end
    // high band: integers 54..84 only, unused bits written as ones
    for (int n = 0; n < 4; n++)
    begin
      wr(8'h24 + 8'(16 * n), 8'h80 | 8'(54 + 10 * n));
      wr(8'h28 + 8'(16 * n), fr[n][7:0]);
      wr(8'h2c + 8'(16 * n), fr[n][15:8]);
      wr(8'h30 + 8'(16 * n), {3'h7, fr[n][20:16]});
      rd_chk(8'h24 + 8'(16 * n), 8'h80 | 8'(54 + 10 * n));
      rd_chk(8'h30 + 8'(16 * n), {3'h6, fr[n][20:16]});
    end
    settle();
    chk("integer_ratio", 32'h40, integer_ratio);
    for (int n = 0; n < 4; n++)
    begin
      wr(8'hc0, 8'(n));
      settle();
      chk("active_chan", 32'(n), active_chan);
      chk("integer_ratio", 32'(54 + 10 * n), integer_ratio);
      chk("fraction_ratio", {11'h0, fr[n]}, fraction_ratio);
      hi = (mmd_factor === 8'(54 + 10 * n) ||
            mmd_factor === 8'(55 + 10 * n)) ? 1 : 0;
      chk("mmd_factor_range", 32'h1, 32'(hi));
    end
    // low band masks bit 6 of the active integer
    wr(8'h10, 8'h02);
    settle();
    chk("integer_ratio", 32'h14, integer_ratio);
    wr(8'h54, 8'h6b);
    settle();
    chk("integer_ratio", 32'h14, integer_ratio);
    wr(8'hc0, 8'h03);
    settle();
    chk("integer_ratio", 32'h2b, integer_ratio);
    rd_chk(8'hc0, 8'h03);
    // near one half fraction: about every second factor carries
    wr(8'hc0, 8'h00);
    settle();
    hi = 0;
    repeat (64)
    begin
      @(negedge clock);
      if (mmd_factor === 8'h37)
        hi++;
      else
        chk("mmd_factor", 32'h36, mmd_factor);
    end
    chk("carry_count", 32'h1, 32'(hi == 32 || hi == 33));
    rd_chk(8'hfc, 8'h00);
    bus(1'b1, 4'h0, 8'h10, 32'h0000000c);
    rd_chk(8'h10, 8'h02);
    rd_chk(8'hc4, 8'h8c);
    conclude();
  end
endmodule

`default_nettype wire
